// ==== pkg/seq_pkg.sv ====
// Purpose: shared constants and types for the program sequencer
// Assumes: 11-bit program space of 14-bit words, 4-level return stack
// Notes: vectors are placed at plain defaults
package seq_pkg;
    localparam int PC_W = 11;
    localparam int WORD_W = 14;
    localparam int STACK_DEPTH = 4;
    localparam int SP_W = 3;
    localparam int PHASES = 4;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;
    localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
    localparam logic [PC_W-1:0] EXT_VECTOR = 11'h004;
    localparam logic [PC_W-1:0] TMR_VECTOR = 11'h008;
    localparam logic [PC_W-1:0] ADC_VECTOR = 11'h00C;
    localparam logic [2:0] LAST_PAGE = 3'h7;
    localparam logic [1:0] PHASE_T1 = 2'h0;
    localparam logic [1:0] PHASE_T4 = 2'h3;
    localparam int TIME_NS = 5;

    typedef enum logic [3:0] {
        OP_NONE, OP_JUMP, OP_CALL, OP_RET, OP_RETURN_FROM_INTERRUPT, OP_SKIP,
        OP_PCL_WR, OP_TBL_CUR, OP_TBL_LAST
    } seq_op_t;

    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR,
        ALU_XOR, ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC,
        ALU_DEC, ALU_PASS
    } alu_op_t;

    typedef struct packed {
        seq_op_t op;
        logic skip_taken;
        logic [PC_W-1:0] target;
        logic [7:0] pcl_data;
    } seq_cmd_t;

    typedef struct packed {
        logic carry;
        logic aux_carry;
        logic zero;
        logic overflow;
    } alu_flags_t;
endpackage

// ==== logic/program_sequencer_with_stack.sv ====
// Purpose: PC, return stack, vectors, table reads and ALU of an 8-bit core
// Assumes: decoder issues one seq_cmd_t per instruction cycle, at T4
// Notes: one instruction cycle is four i_core_clk phases
`timescale 1ns/1ps
`default_nettype none

module program_sequencer_with_stack #(
    parameter int STACK_LEVELS = seq_pkg::STACK_DEPTH
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Decoded instruction
    input wire seq_pkg::seq_cmd_t i_cmd,
    input wire logic [7:0] i_table_ptr,
    // Interrupt sources
    input wire logic i_ext_pin,
    input wire logic [1:0] i_ext_edge_sel,
    input wire logic i_ext_en,
    input wire logic i_tmr_ovf,
    input wire logic i_tmr_en,
    input wire logic i_adc_done,
    input wire logic i_adc_en,
    // Program memory
    input wire logic [seq_pkg::WORD_W-1:0] i_prog_word,
    output logic [seq_pkg::PC_W-1:0] o_prog_addr,
    output logic [seq_pkg::WORD_W-1:0] o_instr,
    output logic o_instr_valid,
    // Program-visible state
    output logic [7:0] o_pc_low_byte,
    output logic [7:0] o_table_low,
    output logic o_table_low_valid,
    output logic [5:0] o_table_high_latch,
    output logic [1:0] o_phase,
    output logic o_int_ack,
    output logic [2:0] o_int_pending,
    // ALU
    input wire seq_pkg::alu_op_t i_alu_op,
    input wire logic [7:0] i_alu_a,
    input wire logic [7:0] i_alu_b,
    input wire seq_pkg::alu_flags_t i_flags,
    output logic [7:0] o_alu_result,
    output seq_pkg::alu_flags_t o_alu_flags
);
    import seq_pkg::*;

    logic [1:0] phase;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] stack [STACK_LEVELS];
    logic [SP_W-1:0] sp;
    logic dummy;
    logic tbl_second;
    logic [PC_W-1:0] tbl_addr;
    logic pin_s1, pin_s2, pin_s3;
    logic [2:0] pend;

    wire is_t1 = (phase == PHASE_T1);
    wire is_t4 = (phase == PHASE_T4);
    wire stack_full = (sp == SP_W'(STACK_LEVELS));
    wire stack_empty = (sp == SP_RESET);
    wire rise = pin_s2 & ~pin_s3;
    wire fall = ~pin_s2 & pin_s3;
    // Edge select: 01 falling, 10 rising, 11 both
    wire ext_evt = (i_ext_edge_sel[0] & fall) | (i_ext_edge_sel[1] & rise);
    wire [2:0] evt = {i_adc_done & i_adc_en, i_tmr_ovf & i_tmr_en,
                      ext_evt & i_ext_en};
    wire is_call = (i_cmd.op == OP_CALL);
    wire is_ret = (i_cmd.op == OP_RET) || (i_cmd.op == OP_RETURN_FROM_INTERRUPT);
    wire is_tbl = (i_cmd.op == OP_TBL_CUR) || (i_cmd.op == OP_TBL_LAST);
    wire cmd_ok = is_t4 & ~dummy & ~tbl_second;
    // Acknowledge only between instructions and with room on the stack
    wire take_int = cmd_ok & (pend != 3'h0) & ~stack_full & ~is_call &
                    (i_cmd.op == OP_NONE);
    wire [2:0] ack_onehot = pend & (~pend + 3'h1);
    wire [PC_W-1:0] int_vec = ack_onehot[0] ? EXT_VECTOR :
                              ack_onehot[1] ? TMR_VECTOR : ADC_VECTOR;
    wire [PC_W-1:0] tbl_cur = {pc[PC_W-1:8], i_table_ptr};
    wire [PC_W-1:0] tbl_last = {LAST_PAGE, i_table_ptr};

    logic [PC_W-1:0] next_pc;
    logic next_dummy;
    always_comb begin
        next_pc = pc;
        next_dummy = 1'b0;
        if (cmd_ok) begin
            next_pc = pc + 11'h001;
            if (take_int) begin
                next_pc = int_vec;
                next_dummy = 1'b1;
            end else begin
                case (i_cmd.op)
                    OP_JUMP, OP_CALL: begin
                        next_pc = i_cmd.target;
                        next_dummy = 1'b1;
                    end
                    OP_RET, OP_RETURN_FROM_INTERRUPT: begin
                        next_pc = stack[SP_W'(sp - 3'h1) % STACK_LEVELS];
                        next_dummy = 1'b1;
                    end
                    OP_SKIP: begin
                        next_dummy = i_cmd.skip_taken;
                    end
                    OP_PCL_WR: begin
                        next_pc = {pc[PC_W-1:8], i_cmd.pcl_data};
                        next_dummy = 1'b1;
                    end
                    default: begin
                        next_dummy = 1'b0;
                    end
                endcase
            end
        end else if (is_t4) begin
            next_pc = pc + 11'h001;
        end
    end

    // Fetch by PC, table by table address
    assign o_prog_addr = (tbl_second & ~is_t1) ? tbl_addr : pc;
    // Only the low byte is exposed
    assign o_pc_low_byte = pc[7:0];
    assign o_phase = phase;
    assign o_int_pending = pend;

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase <= PHASE_T1;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
        end else begin
            pin_s1 <= i_ext_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pc <= RESET_VECTOR;
            dummy <= 1'b0;
        end else if (is_t4) begin
            pc <= next_pc;
            dummy <= next_dummy;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sp <= SP_RESET;
        end else if (cmd_ok) begin
            // Call on full stack overwrites entry 0 and sp holds at the depth
            if (take_int || is_call) begin
                stack[sp[1:0]] <= pc + 11'h001;
                if (!stack_full) begin
                    sp <= sp + 3'h1;
                end
            end else if (is_ret && !stack_empty) begin
                sp <= sp - 3'h1;
            end
        end
    end

    // Flags stay pending while stack is full
    // One acknowledge clears only one source
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pend <= 3'h0;
            o_int_ack <= 1'b0;
        end else begin
            pend <= (pend & ~(take_int ? ack_onehot : 3'h0)) | evt;
            o_int_ack <= take_int;
        end
    end

    // Table read occupies a second cycle
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tbl_second <= 1'b0;
            tbl_addr <= RESET_VECTOR;
            o_table_high_latch <= 6'h00;
            o_table_low <= 8'h00;
            o_table_low_valid <= 1'b0;
        end else begin
            o_table_low_valid <= 1'b0;
            if (cmd_ok && is_tbl) begin
                tbl_second <= 1'b1;
                tbl_addr <= (i_cmd.op == OP_TBL_LAST) ? tbl_last : tbl_cur;
            end else if (tbl_second && is_t4) begin
                // Split word into data and latch
                tbl_second <= 1'b0;
                o_table_low <= i_prog_word[7:0];
                o_table_high_latch <= i_prog_word[WORD_W-1:8];
                o_table_low_valid <= 1'b1;
            end
        end
    end

    // Dummy cycle suppresses the fetched word
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_instr <= 14'h0000;
            o_instr_valid <= 1'b0;
        end else begin
            o_instr_valid <= is_t1 & ~dummy & ~tbl_second;
            if (is_t1) begin
                o_instr <= i_prog_word;
            end
        end
    end

    logic [8:0] sum;
    logic [7:0] adj;
    always_comb begin
        sum = 9'h000;
        adj = 8'h00;
        case (i_alu_op)
            ALU_ADD: sum = {1'b0, i_alu_a} + {1'b0, i_alu_b};
            ALU_ADC: sum = {1'b0, i_alu_a} + {1'b0, i_alu_b} +
                           {8'h00, i_flags.carry};
            ALU_SUB: sum = {1'b0, i_alu_a} + {1'b0, ~i_alu_b} + 9'h001;
            ALU_SBC: sum = {1'b0, i_alu_a} + {1'b0, ~i_alu_b} +
                           {8'h00, i_flags.carry};
            ALU_DAA: begin
                adj[3:0] = (i_alu_a[3:0] > 4'h9 || i_flags.aux_carry) ?
                           4'h6 : 4'h0;
                adj[7:4] = (i_alu_a[7:4] > 4'h9 || i_flags.carry) ?
                           4'h6 : 4'h0;
                sum = {1'b0, i_alu_a} + {1'b0, adj};
            end
            ALU_AND: sum = {i_flags.carry, i_alu_a & i_alu_b};
            ALU_OR: sum = {i_flags.carry, i_alu_a | i_alu_b};
            ALU_XOR: sum = {i_flags.carry, i_alu_a ^ i_alu_b};
            ALU_CPL: sum = {i_flags.carry, ~i_alu_a};
            ALU_RR: sum = {i_flags.carry, i_alu_a[0], i_alu_a[7:1]};
            ALU_RRC: sum = {i_alu_a[0], i_flags.carry, i_alu_a[7:1]};
            ALU_RL: sum = {i_flags.carry, i_alu_a[6:0], i_alu_a[7]};
            ALU_RLC: sum = {i_alu_a, i_flags.carry};
            ALU_INC: sum = {i_flags.carry, i_alu_a + 8'h01};
            ALU_DEC: sum = {i_flags.carry, i_alu_a - 8'h01};
            default: sum = {i_flags.carry, i_alu_a};
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_alu_result <= 8'h00;
            o_alu_flags <= '0;
        end else if (is_t4) begin
            o_alu_result <= sum[7:0];
            o_alu_flags.carry <= sum[8];
            o_alu_flags.zero <= (sum[7:0] == 8'h00);
            o_alu_flags.aux_carry <= (i_alu_a[3:0] + i_alu_b[3:0]) > 5'h0F;
            o_alu_flags.overflow <= (i_alu_a[7] == i_alu_b[7]) &&
                                    (sum[7] != i_alu_a[7]);
        end
    end

    chk_pc_steps: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst)
        (cmd_ok && i_cmd.op == OP_NONE && !take_int) |=>
        pc == $past(pc) + 11'h001)
        else $error("pc did not advance by one");
    chk_pcl_page: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst)
        (cmd_ok && i_cmd.op == OP_PCL_WR && !take_int) |=>
        pc[10:8] == $past(pc[10:8]) && dummy)
        else $error("pcl write left page or no dummy");
    chk_full_block: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst)
        stack_full |-> !take_int)
        else $error("interrupt taken on full stack");
    chk_sp_bound: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst)
        sp <= SP_W'(STACK_LEVELS))
        else $error("stack pointer past depth");
    chk_phase_wrap: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst)
        is_t4 |=> is_t1 ##3 is_t4)
        else $error("phase sequence broken");
    chk_tbl_two: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst)
        (cmd_ok && is_tbl) |=> tbl_second [*4] ##1 !tbl_second)
        else $error("table read not two cycles");
    chk_last_page: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst)
        (cmd_ok && i_cmd.op == OP_TBL_LAST) |=> tbl_addr[10:8] == LAST_PAGE)
        else $error("last page address wrong");
    chk_one_ack: assert property (@(posedge i_core_clk)
        disable iff (i_sys_rst)
        take_int |-> $onehot(ack_onehot))
        else $error("more than one acknowledge");

    cov_call: cover property (@(posedge i_core_clk) cmd_ok && is_call);
    cov_int: cover property (@(posedge i_core_clk) take_int);
    cov_full: cover property (@(posedge i_core_clk) stack_full && pend != 0);
    cov_tbl: cover property (@(posedge i_core_clk) o_table_low_valid);
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the program sequencer
// Assumes: combinational program memory modelled from the address
// Notes: driver queues table words and vectors, a monitor compares them
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import seq_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    seq_cmd_t i_cmd = '0;
    logic [7:0] i_table_ptr = 8'h00;
    logic i_ext_pin = 1'b1;
    logic [1:0] i_ext_edge_sel = 2'h1;
    logic i_tmr_ovf = 1'b0;
    logic i_adc_done = 1'b0;
    logic i_en = 1'b1;
    alu_op_t i_alu_op = ALU_ADD;
    logic [7:0] i_alu_a = 8'h00;
    logic [7:0] i_alu_b = 8'h00;
    alu_flags_t i_flags = '0;
    wire logic [WORD_W-1:0] i_prog_word;
    logic [PC_W-1:0] o_prog_addr;
    logic [WORD_W-1:0] o_instr;
    logic o_instr_valid, o_table_low_valid, o_int_ack;
    logic [7:0] o_pc_low_byte, o_table_low, o_alu_result;
    logic [5:0] o_table_high_latch;
    logic [1:0] o_phase;
    logic [2:0] o_int_pending;
    alu_flags_t o_alu_flags;
    int err_total = 0;
    int num_checks = 0;
    int n_valid = 0;
    int n_ack = 0;
    int seed = 32'h2879;
    logic [WORD_W-1:0] q_tbl[$];
    logic [PC_W-1:0] q_ack[$];
    logic [PC_W-1:0] pc_now, tgt;
    logic [PC_W-1:0] ret_addr[4];
    logic [5:0] last_high = 6'h00;
    alu_op_t ops[5] = '{ALU_ADD, ALU_AND, ALU_OR, ALU_XOR, ALU_CPL};

    always #2.5 i_core_clk = ~i_core_clk;

    // Memory contents are a pure function of the address
    function automatic logic [WORD_W-1:0] mem_word(logic [PC_W-1:0] a);
        return {a[10:5], a[7:0] ^ 8'h5A};
    endfunction
    assign i_prog_word = mem_word(o_prog_addr);

    program_sequencer_with_stack dut (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_cmd(i_cmd),
        .i_table_ptr(i_table_ptr), .i_ext_pin(i_ext_pin),
        .i_ext_edge_sel(i_ext_edge_sel), .i_ext_en(i_en),
        .i_tmr_ovf(i_tmr_ovf), .i_tmr_en(i_en), .i_adc_done(i_adc_done),
        .i_adc_en(i_en), .i_prog_word(i_prog_word),
        .o_prog_addr(o_prog_addr), .o_instr(o_instr),
        .o_instr_valid(o_instr_valid), .o_pc_low_byte(o_pc_low_byte),
        .o_table_low(o_table_low), .o_table_low_valid(o_table_low_valid),
        .o_table_high_latch(o_table_high_latch), .o_phase(o_phase),
        .o_int_ack(o_int_ack), .o_int_pending(o_int_pending),
        .i_alu_op(i_alu_op), .i_alu_a(i_alu_a), .i_alu_b(i_alu_b),
        .i_flags(i_flags), .o_alu_result(o_alu_result),
        .o_alu_flags(o_alu_flags));

    task automatic report(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic check_addr(input logic [PC_W-1:0] got,
        input logic [PC_W-1:0] exp);
        report(16'(got), 16'(exp));
    endtask
    task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
        report(16'(got), 16'(exp));
    endtask
    task automatic check_count(input int got, input int exp);
        report(16'(got), 16'(exp));
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Sampling at posedge sees settled values from the cycle before
    always @(posedge i_core_clk) begin
        if (o_instr_valid === 1'b1) n_valid++;
        if (o_table_low_valid === 1'b1) begin
            if (q_tbl.size() > 0) begin
                check_data(o_table_low, q_tbl[0][7:0]);
                check_data(8'(o_table_high_latch), 8'(q_tbl[0][13:8]));
                last_high = q_tbl[0][13:8];
                void'(q_tbl.pop_front());
            end else check_count(1, 0);
        end
        if (o_int_ack === 1'b1) begin
            n_ack++;
            if (q_ack.size() > 0) begin
                tgt = q_ack.pop_front();
                check_addr(o_prog_addr, tgt);
            end else begin
                check_count(1, 0);
            end
        end
    end

    task automatic to_t4;
        int n;
        n = 0;
        @(negedge i_core_clk);
        while (o_phase !== PHASE_T4 && n < 20) begin
            @(negedge i_core_clk);
            n++;
        end
    endtask
    task automatic issue(input seq_op_t op, input logic [PC_W-1:0] t,
        input logic [7:0] d, input logic skip);
        to_t4();
        pc_now = o_prog_addr;
        i_cmd = '{op: op, skip_taken: skip, target: t, pcl_data: d};
        i_table_ptr = d;
        @(negedge i_core_clk);
        i_cmd.op = OP_NONE;
    endtask
    // Counts fetch pulses over one instruction cycle
    task automatic fetches(input int exp);
        int v0;
        v0 = n_valid;
        repeat (4) @(negedge i_core_clk);
        check_count(n_valid - v0, exp);
    endtask
    task automatic wait_ack(input int exp);
        int n;
        n = 0;
        while (n_ack < exp && n < 40) begin
            @(negedge i_core_clk);
            n++;
        end
        check_count(n_ack, exp);
        repeat (4) @(negedge i_core_clk);
    endtask
    task automatic do_reset;
        i_sys_rst = 1'b1;
        repeat (5) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        check_addr(o_prog_addr, RESET_VECTOR);
        check_data(8'(o_table_high_latch), 8'h00);
        check_data(8'(o_int_pending), 8'h00);
    endtask

    initial begin
        #100000;
        err_total++;
        print_verdict();
    end

    initial begin
        do_reset();
        tgt = 11'($random(seed));
        tgt[7] = 1'b0;
        issue(OP_JUMP, tgt, 8'h00, 1'b0);
        check_addr(o_prog_addr, tgt);
        fetches(0);
        issue(OP_NONE, 11'h000, 8'h00, 1'b0);
        check_addr(o_prog_addr, pc_now + 11'h001);
        for (int s = 0; s < 2; s++) begin
            issue(OP_SKIP, 11'h000, 8'h00, s[0]);
            fetches(1 - s);
        end
        issue(OP_PCL_WR, 11'h000, 8'h3C, 1'b0);
        check_addr(o_prog_addr, {pc_now[10:8], 8'h3C});
        check_data(o_pc_low_byte, 8'h3C);
        fetches(0);
        for (int i = 0; i < 6; i++) begin
            issue(i < 3 ? OP_TBL_CUR : OP_TBL_LAST, 11'h000,
                8'($random(seed)), 1'b0);
            q_tbl.push_back(mem_word({i < 3 ? pc_now[10:8] : LAST_PAGE,
                i_table_ptr}));
            repeat (4) @(negedge i_core_clk);
        end
        for (int i = 0; i < 5; i++) begin
            to_t4();
            i_alu_op = ops[i];
            i_alu_a = 8'($random(seed));
            i_alu_b = 8'($random(seed));
            i_flags = 4'($random(seed));
            @(negedge i_core_clk);
            case (ops[i])
                ALU_ADD: tgt = 11'(i_alu_a) + 11'(i_alu_b);
                ALU_AND: tgt = 11'(i_alu_a & i_alu_b);
                ALU_OR: tgt = 11'(i_alu_a | i_alu_b);
                ALU_XOR: tgt = 11'(i_alu_a ^ i_alu_b);
                default: tgt = 11'(~i_alu_a);
            endcase
            check_data(o_alu_result, tgt[7:0]);
            check_data(8'(o_alu_flags.zero), 8'(tgt[7:0] == 8'h00));
            if (i == 0) begin
                check_data(8'(o_alu_flags.carry), 8'(tgt[8]));
            end
        end
        for (int i = 0; i < 4; i++) begin
            issue(OP_CALL, 11'h100 * i[2:0] + 11'h020, 8'h00, 1'b0);
            ret_addr[i] = pc_now + 11'h001;
            check_addr(o_prog_addr, 11'h100 * i[2:0] + 11'h020);
            fetches(0);
        end
        i_ext_pin = 1'b0;
        i_tmr_ovf = 1'b1;
        i_adc_done = 1'b1;
        @(negedge i_core_clk);
        i_tmr_ovf = 1'b0;
        i_adc_done = 1'b0;
        repeat (12) @(negedge i_core_clk);
        check_data(8'(o_int_pending), 8'h07);
        check_count(n_ack, 0);
        q_ack = '{EXT_VECTOR, TMR_VECTOR, ADC_VECTOR};
        issue(OP_RET, 11'h000, 8'h00, 1'b0);
        check_addr(o_prog_addr, ret_addr[3]);
        wait_ack(1);
        for (int i = 2; i <= 4; i++) begin
            issue(OP_RETURN_FROM_INTERRUPT, 11'h000, 8'h00, 1'b0);
            if (i < 4) wait_ack(i);
        end
        for (int i = 2; i >= 0; i--) begin
            repeat (4) @(negedge i_core_clk);
            issue(OP_RET, 11'h000, 8'h00, 1'b0);
            check_addr(o_prog_addr, ret_addr[i]);
        end
        check_data(8'(o_table_high_latch), 8'(last_high));
        do_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
